// [logic/bems_top.sv]
// Bus event monitor selection: two bus event selectors, four counter configurations,
// a Wishbone slave for software access and one count strobe per counter.
// Assumes a classic Wishbone master, core clock ref_clk_i at 50 MHz, and sub-event
// pulses from the bus unit that are synchronous to that clock.

`timescale 1ns/1ps

module bems_top (
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // Classic Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Bus sub-event pulses, one line per mask bit.
    input  wire logic [15:0] b2b_sub_i,
    input  wire logic [15:0] bnr_sub_i,
    input  wire logic [15:0] snoop_sub_i,
    input  wire logic [15:0] resp_sub_i,
    // Count strobes towards counters 0 to 3.
    output logic [3:0]       count_inc_o
);
    import bems_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum logic {
        BEMS_BUS_IDLE,
        BEMS_BUS_ACK
    } bems_bus_state_t;

    bems_bus_state_t bus_state;
    bems_bus_state_t next_bus_state;

    logic [31:0]     bus_event_selector_first;
    logic [31:0]     bus_event_selector_second;
    logic [31:0]     counter_configuration_control_reg [BEMS_NUM_CNT];
    logic [3:0]      hit_flags;
    logic [3:0]      hit_now;
    bems_event_t     event_kind [BEMS_NUM_CNT];
    logic            req;
    logic            wr_take;
    logic            rd_take;
    logic [31:0]     byte_mask;
    logic [31:0]     next_rd_data;
    logic [3:0]      flag_clear;
    logic [3:0]      active;

    // ------------------------------------------------------------------
    // Wishbone handshake
    // ------------------------------------------------------------------
    // A request is answered one clock after it is seen; ack then drops for
    // a cycle, so a request that stays held is taken again every other cycle.
    assign req = wb_cyc_i && wb_stb_i;

    always_comb begin
        next_bus_state = bus_state;
        unique case (bus_state)
            BEMS_BUS_IDLE: begin
                if (req) begin
                    next_bus_state = BEMS_BUS_ACK;
                end
            end
            BEMS_BUS_ACK: begin
                next_bus_state = BEMS_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_state <= BEMS_BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    // Ack is combinational from state; the request is still held here.
    assign wb_ack_o = (bus_state == BEMS_BUS_ACK) && req;

    // Writes land on the edge at which the master samples ack.
    assign wr_take = wb_ack_o && wb_we_i;
    assign rd_take = (bus_state == BEMS_BUS_IDLE) && req && !wb_we_i;

    // Expand byte selects to a bit mask for partial writes.
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            byte_mask[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
    end

    // ------------------------------------------------------------------
    // Selector registers
    // ------------------------------------------------------------------
    // The first selector steers counters 0 and 1, the second 2 and 3.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_event_selector_first  <= BEMS_SEL_RESET;
            bus_event_selector_second <= BEMS_SEL_RESET;
        end else if (wr_take) begin
            if (wb_adr_i == BEMS_OFS_SEL_FIRST) begin
                bus_event_selector_first <= (bus_event_selector_first & ~byte_mask)
                                          | (wb_dat_i & byte_mask);
            end
            if (wb_adr_i == BEMS_OFS_SEL_SECOND) begin
                bus_event_selector_second <= (bus_event_selector_second & ~byte_mask)
                                           | (wb_dat_i & byte_mask);
            end
        end
    end

    // ------------------------------------------------------------------
    // Counter configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int k = 0; k < BEMS_NUM_CNT; k++) begin
                counter_configuration_control_reg[k] <= BEMS_CFG_RESET;
            end
        end else if (wr_take) begin
            for (int k = 0; k < BEMS_NUM_CNT; k++) begin
                if (wb_adr_i == BEMS_OFS_CFG0 + 8'(k * 4)) begin
                    counter_configuration_control_reg[k] <=
                        (counter_configuration_control_reg[k] & ~byte_mask)
                        | (wb_dat_i & byte_mask);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-counter event decode
    // ------------------------------------------------------------------
    // Counters 0-1 take the first selector and 2-3 the second, so a single
    // selector write retargets a pair of counters at once.
    for (genvar k = 0; k < BEMS_NUM_CNT; k++) begin : g_decode
        bems_counter_decode u_decode (
            .selector_i  ((k < 2) ? bus_event_selector_first
                                  : bus_event_selector_second),
            .config_i    (counter_configuration_control_reg[k]),
            .b2b_sub_i   (b2b_sub_i),
            .bnr_sub_i   (bnr_sub_i),
            .snoop_sub_i (snoop_sub_i),
            .resp_sub_i  (resp_sub_i),
            .event_o     (event_kind[k]),
            .hit_o       (hit_now[k])
        );
        assign active[k] = (event_kind[k] != BEMS_EV_NONE);
    end

    // ------------------------------------------------------------------
    // Count strobes
    // ------------------------------------------------------------------
    // Registered to keep the decode path off the counter carry chain; the
    // cost is one cycle of latency from sub-event to strobe.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_inc_o <= 4'h0;
        end else begin
            count_inc_o <= hit_now;
        end
    end

    // ------------------------------------------------------------------
    // Sticky hit flags
    // ------------------------------------------------------------------
    // Software clears a flag by writing one; a hit in the same cycle wins,
    // so no event observed during the clear goes unreported.
    assign flag_clear = (wr_take && wb_adr_i == BEMS_OFS_HIT_FLAGS && wb_sel_i[0])
                      ? wb_dat_i[3:0] : 4'h0;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hit_flags <= 4'h0;
        end else begin
            hit_flags <= (hit_flags & ~flag_clear) | hit_now;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Unmapped addresses read as zero and ignore writes but are still acked,
    // so a stray access never hangs the bus.
    always_comb begin
        next_rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            BEMS_OFS_SEL_FIRST:  next_rd_data = bus_event_selector_first;
            BEMS_OFS_SEL_SECOND: next_rd_data = bus_event_selector_second;
            BEMS_OFS_CFG0:       next_rd_data = counter_configuration_control_reg[0];
            BEMS_OFS_CFG1:       next_rd_data = counter_configuration_control_reg[1];
            BEMS_OFS_CFG2:       next_rd_data = counter_configuration_control_reg[2];
            BEMS_OFS_CFG3:       next_rd_data = counter_configuration_control_reg[3];
            BEMS_OFS_STATUS: begin
                for (int k = 0; k < BEMS_NUM_CNT; k++) begin
                    next_rd_data[k*4 +: 3] = event_kind[k];
                    next_rd_data[k*4 + 3]  = active[k];
                end
            end
            BEMS_OFS_HIT_FLAGS:  next_rd_data = {28'h000_0000, hit_flags};
            default:             next_rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_take) begin
            wb_dat_o <= next_rd_data;
        end
    end

endmodule

// [logic/bems_pkg.sv]
// Constants, field layout and register map of the bus event monitor selection block.
// Assumes a classic Wishbone host with 32-bit data and a core clock of 50 MHz.

package bems_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on the Wishbone bus)
    // ------------------------------------------------------------------
    localparam logic [7:0] BEMS_OFS_SEL_FIRST  = 8'h00;
    localparam logic [7:0] BEMS_OFS_SEL_SECOND = 8'h04;
    localparam logic [7:0] BEMS_OFS_CFG0       = 8'h10;
    localparam logic [7:0] BEMS_OFS_CFG1       = 8'h14;
    localparam logic [7:0] BEMS_OFS_CFG2       = 8'h18;
    localparam logic [7:0] BEMS_OFS_CFG3       = 8'h1C;
    localparam logic [7:0] BEMS_OFS_STATUS     = 8'h20;
    localparam logic [7:0] BEMS_OFS_HIT_FLAGS  = 8'h24;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BEMS_CODE_MSB     = 30;
    localparam int BEMS_CODE_LSB     = 25;
    localparam int BEMS_MASK_MSB     = 24;
    localparam int BEMS_MASK_LSB     = 9;
    localparam int BEMS_CSEL_MSB     = 15;
    localparam int BEMS_CSEL_LSB     = 13;
    localparam int BEMS_CFG_EN_BIT   = 12;
    localparam int BEMS_NUM_CNT      = 4;
    localparam int BEMS_SUB_W        = 16;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] BEMS_SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] BEMS_CFG_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Event codes, counter select and permitted sub-event masks
    // ------------------------------------------------------------------
    localparam logic [5:0]  BEMS_CODE_B2B    = 6'h16;
    localparam logic [5:0]  BEMS_CODE_BNR    = 6'h08;
    localparam logic [5:0]  BEMS_CODE_SNOOP  = 6'h06;
    localparam logic [5:0]  BEMS_CODE_RESP   = 6'h04;
    localparam logic [2:0]  BEMS_CSEL_BUS    = 3'h3;
    localparam logic [15:0] BEMS_ALLOW_B2B   = 16'h007E;
    localparam logic [15:0] BEMS_ALLOW_BNR   = 16'h0007;
    localparam logic [15:0] BEMS_ALLOW_SNOOP = 16'h00C4;
    localparam logic [15:0] BEMS_ALLOW_RESP  = 16'h0306;

    // Bus event class chosen by a counter.
    typedef enum logic [2:0] {
        BEMS_EV_NONE,
        BEMS_EV_B2B,
        BEMS_EV_BNR,
        BEMS_EV_SNOOP,
        BEMS_EV_RESP
    } bems_event_t;

endpackage

// [logic/bems_counter_decode.sv]
// Per-counter decode: turns one selector and one counter configuration into a count strobe.
// Assumes sub-event lines are synchronous one-cycle pulses on the core clock.

`timescale 1ns/1ps

module bems_counter_decode (
    input  wire logic [31:0]          selector_i,
    input  wire logic [31:0]          config_i,
    input  wire logic [15:0]          b2b_sub_i,
    input  wire logic [15:0]          bnr_sub_i,
    input  wire logic [15:0]          snoop_sub_i,
    input  wire logic [15:0]          resp_sub_i,
    output bems_pkg::bems_event_t     event_o,
    output logic                      hit_o
);
    import bems_pkg::*;

    logic [5:0]  code;
    logic [15:0] mask;
    logic [2:0]  csel;
    logic [15:0] qual;

    assign code = selector_i[BEMS_CODE_MSB:BEMS_CODE_LSB];
    assign mask = selector_i[BEMS_MASK_MSB:BEMS_MASK_LSB];
    assign csel = config_i[BEMS_CSEL_MSB:BEMS_CSEL_LSB];

    // ------------------------------------------------------------------
    // Event classification
    // ------------------------------------------------------------------
    // Mask bits outside the documented range of an event are ignored, so
    // stray software bits cannot make a counter tally unrelated traffic.
    always_comb begin
        event_o = BEMS_EV_NONE;
        qual    = 16'h0000;
        hit_o   = 1'b0;
        if (config_i[BEMS_CFG_EN_BIT] && csel == BEMS_CSEL_BUS) begin
            if (code == BEMS_CODE_B2B) begin
                event_o = BEMS_EV_B2B;
                qual    = mask & BEMS_ALLOW_B2B & b2b_sub_i;
            end else if (code == BEMS_CODE_BNR) begin
                event_o = BEMS_EV_BNR;
                qual    = mask & BEMS_ALLOW_BNR & bnr_sub_i;
            end else if (code == BEMS_CODE_SNOOP) begin
                event_o = BEMS_EV_SNOOP;
                qual    = mask & BEMS_ALLOW_SNOOP & snoop_sub_i;
            end else if (code == BEMS_CODE_RESP) begin
                event_o = BEMS_EV_RESP;
                qual    = mask & BEMS_ALLOW_RESP & resp_sub_i;
            end
        end
        hit_o = |qual;
    end

endmodule

// [verification/bems_top_asserts.sv]
// Checker for the bus event monitor selection block, bound to bems_top.
// Assumes only the top ports; register contents are shadowed from Wishbone writes.
`timescale 1ns/1ps
module bems_top_chk
    import bems_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        rstn_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [15:0] b2b_sub_i,
    input wire logic [15:0] bnr_sub_i,
    input wire logic [15:0] snoop_sub_i,
    input wire logic [15:0] resp_sub_i,
    input wire logic [3:0]  count_inc_o
);
    // ----------------------------------------------------------------
    // Shadow registers
    // ----------------------------------------------------------------
    logic [31:0] shd [6];
    logic [3:0]  exp_inc;
    // Writes land at the ack edge, byte by byte, exactly as the slave takes them.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shd <= '{default: 32'h0000_0000};
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
            for (int i = 0; i < 6; i++) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b] && wb_adr_i == (i < 2 ? 8'(4 * i) : 8'(8 + 4 * i)))
                        shd[i][b*8+:8] <= wb_dat_i[b*8+:8];
                end
            end
        end
    end
    // Counters 0 and 1 share the first selector, 2 and 3 the second. The shadow words
    // are passed as arguments so that assertions see their sampled values.
    function automatic logic hit(logic [31:0] sl, logic [31:0] cf, logic [5:0] c,
                                 logic [15:0] a, logic [15:0] s);
        return sl[30:25] == c && cf[15:13] == 3'h3 && cf[12] && |(sl[24:9] & a & s);
    endfunction
    // Expected strobe of each counter for the sub-events of this cycle.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            exp_inc[k] = hit(shd[k/2], shd[2+k], BEMS_CODE_B2B, BEMS_ALLOW_B2B, b2b_sub_i)
                | hit(shd[k/2], shd[2+k], BEMS_CODE_BNR, BEMS_ALLOW_BNR, bnr_sub_i)
                | hit(shd[k/2], shd[2+k], BEMS_CODE_SNOOP, BEMS_ALLOW_SNOOP, snoop_sub_i)
                | hit(shd[k/2], shd[2+k], BEMS_CODE_RESP, BEMS_ALLOW_RESP, resp_sub_i);
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    for (genvar k = 0; k < 4; k++) begin : g_cnt
        AST_B2B: assert property (
            hit(shd[k/2], shd[2+k], BEMS_CODE_B2B, BEMS_ALLOW_B2B, b2b_sub_i)
            |=> count_inc_o[k]) else $error("back-to-back cycle missed");
        AST_BNR: assert property (
            hit(shd[k/2], shd[2+k], BEMS_CODE_BNR, BEMS_ALLOW_BNR, bnr_sub_i)
            |=> count_inc_o[k]) else $error("bus-not-ready missed");
        AST_SNOOP: assert property (
            hit(shd[k/2], shd[2+k], BEMS_CODE_SNOOP, BEMS_ALLOW_SNOOP, snoop_sub_i)
            |=> count_inc_o[k]) else $error("snoop hit missed");
        AST_RESP: assert property (
            hit(shd[k/2], shd[2+k], BEMS_CODE_RESP, BEMS_ALLOW_RESP, resp_sub_i)
            |=> count_inc_o[k]) else $error("response missed");
    end
    AST_ROUTE: assert property (count_inc_o == $past(exp_inc))
        else $error("count strobe differs from selection");
    AST_ACK_SOON: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i ##1 !wb_ack_o)
        else $error("ack not a single pulse");
    cover property (count_inc_o[0] && count_inc_o[1]);
    cover property (count_inc_o[2]);
    cover property (wb_ack_o && !wb_we_i);
endmodule

bind bems_top bems_top_chk u_chk (.ref_clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .b2b_sub_i, .bnr_sub_i,
    .snoop_sub_i, .resp_sub_i, .count_inc_o);

// [verification/tb.sv]
// Self-checking bench for bems_top: Wishbone register access and event selection.
// Assumes the checker is bound separately; the bench drives every input itself.
`timescale 1ns/1ps
module tb;
    import bems_pkg::*;
    logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hF, inc;
    logic [31:0] wdat = 32'h0, rdat;
    logic        ack;
    logic [63:0] sub = 64'h0, nz;
    logic [31:0] rq[$], s0, s1;
    logic [3:0]  cq[$], e;
    logic [15:0] r, al [4];
    logic [5:0]  cd [4];
    int          mismatches = 0, cmp_count = 0;
    bems_top bems_top_inst (.ref_clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .b2b_sub_i(sub[63:48]), .bnr_sub_i(sub[47:32]),
        .snoop_sub_i(sub[31:16]), .resp_sub_i(sub[15:0]), .count_inc_o(inc));
    // 50 MHz core clock.
    always #10 clk = ~clk;
    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    task automatic cmp(input logic [31:0] g, input logic [31:0] x, input string what);
        cmp_count++;
        if (g !== x) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, g, x);
        end
    endtask
    // One compare task for each kind of result.
    task automatic cmp_rd(input logic [31:0] g, input logic [31:0] x);
        cmp(g, x, "read data");
    endtask
    task automatic cmp_inc(input logic [3:0] g, input logic [3:0] x);
        cmp(32'(g), 32'(x), "count strobes");
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Read data is taken at the ack edge; strobes are looked at mid-cycle.
    always @(posedge clk) begin
        if (ack === 1'b1 && !we && rq.size() > 0) cmp_rd(rdat, rq.pop_front());
    end
    always @(negedge clk) begin
        if (cq.size() > 0) cmp_inc(inc, cq.pop_front());
    end
    // ----------------------------------------------------------------
    // Drivers
    // ----------------------------------------------------------------
    // One classic cycle; the bound guards against a slave that never answers.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            mismatches++;
            end_sim();
        end
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        rq.push_back(x);
        bus(0, a, 32'h0, 4'hF);
    endtask
    // Sub-events for one cycle, then the expected strobes in the next.
    task automatic ev(input logic [63:0] v, input logic [3:0] x);
        @(posedge clk);
        sub <= v;
        @(posedge clk);
        sub <= 64'h0;
        cq.push_back(x);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h17a20a41));
        cd = '{BEMS_CODE_B2B, BEMS_CODE_BNR, BEMS_CODE_SNOOP, BEMS_CODE_RESP};
        al = '{BEMS_ALLOW_B2B, BEMS_ALLOW_BNR, BEMS_ALLOW_SNOOP, BEMS_ALLOW_RESP};
        repeat (6) @(posedge clk);
        rstn <= 1;
        foreach (cd[i]) rd(8'h10 + 8'(4 * i), BEMS_CFG_RESET);
        bus(1, 8'h40, 32'hFFFF_FFFF, 4'hF);
        rd(8'h40, 32'h0);
        // Only byte 1 of this word may land, which enables counter 1.
        bus(1, BEMS_OFS_CFG1, 32'hAAAA_7055, 4'h2);
        bus(1, BEMS_OFS_CFG0, 32'h0000_7000, 4'hF);
        bus(1, BEMS_OFS_CFG2, 32'h0000_7000, 4'hF);
        bus(1, BEMS_OFS_CFG3, 32'h0000_6000, 4'hF);
        rd(BEMS_OFS_CFG1, 32'h0000_7000);
        foreach (cd[c]) begin
            s0 = {1'b0, cd[c], 16'hFFFF, 9'h0};
            s1 = {1'b0, cd[c], 16'($urandom), 9'h0};
            bus(1, BEMS_OFS_SEL_FIRST, s0, 4'hF);
            bus(1, BEMS_OFS_SEL_SECOND, s1, 4'hF);
            rd(BEMS_OFS_SEL_SECOND, s1);
            repeat (6) begin
                r = 16'($urandom);
                e = {1'b0, |(r & al[c] & s1[24:9]), {2{|(r & al[c])}}};
                // Noise goes only to the other three lanes, which these counters ignore.
                nz = {$urandom, $urandom} & ~(64'hFFFF << (16 * (3 - c)));
                ev((64'(r) << (16 * (3 - c))) | nz, e);
            end
            ev(64'(16'(~al[c])) << (16 * (3 - c)), 4'h0);
        end
        // Status shows the response class on the three enabled counters.
        rd(BEMS_OFS_STATUS, 32'h0000_0CCC);
        // Flags clear on a write of ones, then one response hit sets them again.
        bus(1, BEMS_OFS_HIT_FLAGS, 32'h0000_000F, 4'hF);
        rd(BEMS_OFS_HIT_FLAGS, 32'h0000_0000);
        ev(64'h0000_0000_0000_0002, {1'b0, s1[10], 2'b11});
        rd(BEMS_OFS_HIT_FLAGS, {28'h000_0000, 1'b0, s1[10], 2'b11});
        // Counter select other than 3, and an unknown code, never count.
        bus(1, BEMS_OFS_CFG2, 32'h0000_5000, 4'hF);
        bus(1, BEMS_OFS_SEL_FIRST, 32'h03FF_FE00, 4'hF);
        ev({64{1'b1}}, 4'h0);
        @(posedge clk);
        rstn <= 0;
        @(posedge clk);
        rstn <= 1;
        rd(BEMS_OFS_CFG0, BEMS_CFG_RESET);
        repeat (3) @(posedge clk);
        end_sim();
    end
endmodule
